// ==== inc/pfcs_pkg.sv ====
package pfcs_pkg;

  // ------------------------------------------------------------
  // Clock and qualification times
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_PCL_NS = 200;
  localparam int T_BOP_NS = 20000;
  localparam int T_OLP_NS = 1000;
  localparam int T_OVP_NS = 12000;
  localparam int T_MODE_NS = 18000;
  localparam int T_DIS_NS = 9000;
  localparam int T_SOFT_NS = 10000;
  // Least times round up to whole cycles
  localparam int PCL_CYC = (T_PCL_NS * CLK_MHZ + 999) / 1000;
  localparam int BOP_CYC = (T_BOP_NS * CLK_MHZ + 999) / 1000;
  localparam int OLP_CYC = (T_OLP_NS * CLK_MHZ + 999) / 1000;
  localparam int OVP_CYC = (T_OVP_NS * CLK_MHZ + 999) / 1000;
  localparam int MODE_CYC = (T_MODE_NS * CLK_MHZ + 999) / 1000;
  localparam int DIS_CYC = (T_DIS_NS * CLK_MHZ + 999) / 1000;
  localparam int SOFT_CYC = (T_SOFT_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;

  // ------------------------------------------------------------
  // Qualifier slots
  // ------------------------------------------------------------
  localparam int Q_PCL = 0;
  localparam int Q_BOP = 1;
  localparam int Q_OLP = 2;
  localparam int Q_OLP_BF = 3;
  localparam int Q_FIRST_OVERVOLTAGE_TRIP = 4;
  localparam int Q_SECOND_OVERVOLTAGE_TRIP = 5;
  localparam int Q_DIS = 6;
  localparam int Q_THR_LO = 7;
  localparam int Q_THR_HI = 8;
  localparam int NQ = 9;
  localparam int Q_CYC [NQ] = '{PCL_CYC, BOP_CYC, OLP_CYC, OLP_CYC,
    OVP_CYC, OVP_CYC, DIS_CYC, MODE_CYC, MODE_CYC};

  // ------------------------------------------------------------
  // Register map (AXI4-Lite, byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam int CTRL_SW_BLOCK = 0;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NEV = 8;
  localparam int EV_LATCH = 7;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SOFT = 3'h1,
    ST_BLOCK = 3'h2,
    ST_HALT = 3'h3,
    ST_DOWN = 3'h4,
    ST_LATCH = 3'h5
  } pfcs_state_t;

  // Comparator flags, all high while the condition holds
  typedef struct packed {
    logic pcl_trip;
    logic bop_low;
    logic bop_high;
    logic olp_low;
    logic olp_raised_low;
    logic first_overvoltage_trip_high;
    logic below_ref;
    logic second_overvoltage_trip_high;
    logic second_overvoltage_trip_release;
    logic thr_low;
    logic supply_det;
    logic vref_ok;
    logic uvlo;
  } pfcs_flags_t;

endpackage

// ==== logic/pfcs_sync.sv ====
`timescale 1ns/100ps
module pfcs_sync
  import pfcs_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        s1[i] <= din[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end

endmodule

// ==== logic/pfcs_qualify.sv ====
`timescale 1ns/100ps
module pfcs_qualify
  import pfcs_pkg::*;
#(
  parameter logic [CNT_W-1:0] CYCLES = 12'h001
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cond,
  output logic qualified
);

  logic [CNT_W-1:0] cnt;

  // ------------------------------------------------------------
  // Level qualifier: high once cond has held CYCLES samples
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !cond) begin
      cnt <= '0;
      qualified <= 1'b0;
    end else if (cnt == CYCLES - 12'h001) begin
      qualified <= 1'b1;
    end else begin
      cnt <= cnt + 12'h001;
    end
  end

endmodule

// ==== logic/pfcs_fault_supervisor.sv ====
// Contract
// [RULE1] A current-limit trip held 200 ns forces the drive low at once for the rest of the cycle.
// [RULE2] A brownout held 20 us stops switching; soft restart only after the high release level.
// [RULE3] Bulk sense under the open-loop level for 1 us powers down; soft restart once above it.
// [RULE4] With boost follower active, bulk sense under the raised level for 1 us disables it.
// [RULE5] First over-voltage held 12 us blocks switching until sense drops below the reference.
// [RULE6] Both over-voltages qualified together block switching until both have released.
// [RULE7] In latch mode a qualified second over-voltage latches a fault cleared only by lockout.
// [RULE8] In auto mode a qualified second over-voltage blocks, then soft restarts on its release.
// [RULE9] Enable input low for 18 us after supply detection selects auto-restart mode.
// [RULE10] Enable input high for 18 us after supply detection selects latch mode.
// [RULE11] Enable input pulled low 9 us with reference up powers down; soft restart on release.
// [RULE12] The minimum off pulse clears the current-limit and drive-on latches above all else.
// [RULE13] While the supply is in undervoltage lockout the drive output is held low.
// [RULE14] Every qualification timer restarts from zero when its condition drops early.
// [RULE15] Latched fault beats power-down, which beats a temporary drive block.
`timescale 1ns/100ps
module pfcs_fault_supervisor
  import pfcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire pfcs_flags_t flags_in,
  input wire logic minimum_off_pulse,
  input wire logic pwm_on_set,
  input wire logic boost_follower_request,
  output logic gate_drive,
  output logic boost_follower_en,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  pfcs_flags_t f;
  logic [NQ-1:0] qcond;
  logic [NQ-1:0] q;
  logic [NQ-1:0] q_prev;
  pfcs_state_t state;
  pfcs_state_t next_state;
  logic [CNT_W-1:0] soft_cnt;
  logic pcl_latch;
  logic bop_hold;
  logic olp_hold;
  logic first_overvoltage_trip_hold;
  logic dual_hold;
  logic second_overvoltage_trip_hold;
  logic dis_hold;
  logic latched;
  logic mode_auto;
  logic mode_done;
  logic bf_kill;
  logic sw_block;
  logic drive_ok;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] irq_stat;
  logic [NEV-1:0] irq_mask;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_go;
  logic [31:0] status_word;

  // ------------------------------------------------------------
  // Input capture and fault qualification
  // ------------------------------------------------------------
  pfcs_sync #(
    .W($bits(pfcs_flags_t))
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(flags_in),
    .dout(f)
  );

  always_comb begin
    qcond = '0;
    qcond[Q_PCL] = f.pcl_trip;
    qcond[Q_BOP] = f.bop_low;
    qcond[Q_OLP] = f.olp_low;
    qcond[Q_OLP_BF] = f.olp_raised_low && boost_follower_en;
    qcond[Q_FIRST_OVERVOLTAGE_TRIP] = f.first_overvoltage_trip_high;
    qcond[Q_SECOND_OVERVOLTAGE_TRIP] = f.second_overvoltage_trip_high;
    qcond[Q_DIS] = f.thr_low && f.vref_ok;
    qcond[Q_THR_LO] = f.thr_low && f.supply_det && !mode_done;
    qcond[Q_THR_HI] = !f.thr_low && f.supply_det && !mode_done;
  end

  // Counters clear whenever their condition drops [RULE14]
  for (genvar i = 0; i < NQ; i++) begin : g_qual
    pfcs_qualify #(
      .CYCLES(CNT_W'(Q_CYC[i]))
    ) u_qual (
      .aclk(aclk),
      .aresetn(aresetn),
      .cond(qcond[i]),
      .qualified(q[i])
    );
  end

  // ------------------------------------------------------------
  // Restart mode detection after supply detection
  // ------------------------------------------------------------
  // Undecided defaults to latch mode, the safer of the two
  always_ff @(posedge aclk) begin
    if (!aresetn || f.uvlo) begin
      mode_auto <= 1'b0;
      mode_done <= 1'b0;
    end else if (!mode_done && q[Q_THR_LO]) begin
      mode_auto <= 1'b1; // [RULE9]
      mode_done <= 1'b1;
    end else if (!mode_done && q[Q_THR_HI]) begin
      mode_auto <= 1'b0; // [RULE10]
      mode_done <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Fault holds; a new qualification wins over its release
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || f.uvlo) begin
      bop_hold <= 1'b0;
      olp_hold <= 1'b0;
      first_overvoltage_trip_hold <= 1'b0;
      dual_hold <= 1'b0;
      second_overvoltage_trip_hold <= 1'b0;
      dis_hold <= 1'b0;
    end else begin
      if (q[Q_BOP]) begin
        bop_hold <= 1'b1; // [RULE2]
      end else if (f.bop_high) begin
        bop_hold <= 1'b0;
      end
      if (q[Q_OLP]) begin
        olp_hold <= 1'b1; // [RULE3]
      end else if (!f.olp_low) begin
        olp_hold <= 1'b0;
      end
      if (q[Q_FIRST_OVERVOLTAGE_TRIP]) begin
        first_overvoltage_trip_hold <= 1'b1; // [RULE5]
      end else if (f.below_ref) begin
        first_overvoltage_trip_hold <= 1'b0;
      end
      if (q[Q_FIRST_OVERVOLTAGE_TRIP] && q[Q_SECOND_OVERVOLTAGE_TRIP]) begin
        dual_hold <= 1'b1; // [RULE6]
      end else if (f.below_ref && f.second_overvoltage_trip_release) begin
        dual_hold <= 1'b0;
      end
      if (q[Q_SECOND_OVERVOLTAGE_TRIP] && mode_auto) begin
        second_overvoltage_trip_hold <= 1'b1; // [RULE8]
      end else if (f.second_overvoltage_trip_release) begin
        second_overvoltage_trip_hold <= 1'b0;
      end
      if (q[Q_DIS]) begin
        dis_hold <= 1'b1; // [RULE11]
      end else if (!f.thr_low) begin
        dis_hold <= 1'b0;
      end
    end
  end

  // Only a lockout cycle clears the latched fault
  always_ff @(posedge aclk) begin
    if (!aresetn || f.uvlo) begin
      latched <= 1'b0;
    end else if (q[Q_SECOND_OVERVOLTAGE_TRIP] && !mode_auto) begin
      latched <= 1'b1; // [RULE7]
    end
  end

  // ------------------------------------------------------------
  // Supervisor state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (f.uvlo) begin
      next_state = ST_DOWN; // [RULE13]
    end else if (latched) begin
      next_state = ST_LATCH; // [RULE15]
    end else if (olp_hold || dis_hold) begin
      next_state = ST_DOWN; // [RULE15]
    end else if (bop_hold || second_overvoltage_trip_hold) begin
      next_state = ST_HALT;
    end else if (first_overvoltage_trip_hold || dual_hold || sw_block) begin
      next_state = ST_BLOCK;
    end else begin
      unique case (state)
        ST_RUN: next_state = ST_RUN;
        ST_SOFT: begin
          if (soft_cnt == CNT_W'(SOFT_CYC - 1)) begin
            next_state = ST_RUN;
          end
        end
        ST_BLOCK: next_state = ST_RUN;
        ST_HALT, ST_DOWN, ST_LATCH: next_state = ST_SOFT;
        default: next_state = ST_DOWN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_DOWN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != ST_SOFT) begin
      soft_cnt <= '0;
    end else begin
      soft_cnt <= soft_cnt + 12'h001;
    end
  end

  // ------------------------------------------------------------
  // Switch drive
  // ------------------------------------------------------------
  assign drive_ok = (state == ST_RUN || state == ST_SOFT) && !f.uvlo;

  always_ff @(posedge aclk) begin
    if (!aresetn || minimum_off_pulse) begin
      pcl_latch <= 1'b0; // [RULE12]
    end else if (q[Q_PCL]) begin
      pcl_latch <= 1'b1; // [RULE1]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || minimum_off_pulse) begin
      gate_drive <= 1'b0; // [RULE12]
    end else if (!drive_ok) begin
      gate_drive <= 1'b0; // [RULE13]
    end else if (q[Q_PCL] || pcl_latch) begin
      gate_drive <= 1'b0; // [RULE1]
    end else if (pwm_on_set) begin
      gate_drive <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Boost follower gating
  // ------------------------------------------------------------
  // Kept off in soft start so an unsettled feedback cannot toggle it
  always_ff @(posedge aclk) begin
    if (!aresetn || !boost_follower_request) begin
      bf_kill <= 1'b0;
    end else if (q[Q_OLP_BF]) begin
      bf_kill <= 1'b1; // [RULE4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boost_follower_en <= 1'b0;
    end else begin
      boost_follower_en <= boost_follower_request && !bf_kill &&
        !q[Q_OLP_BF] && state == ST_RUN; // [RULE4]
    end
  end

  // ------------------------------------------------------------
  // Events and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_prev <= '0;
    end else begin
      q_prev <= q;
    end
  end

  always_comb begin
    ev = q[NEV-1:0] & ~q_prev[NEV-1:0];
    ev[EV_LATCH] = q[Q_SECOND_OVERVOLTAGE_TRIP] && !q_prev[Q_SECOND_OVERVOLTAGE_TRIP] && !mode_auto;
  end

  // A new event wins over a same-cycle write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else if (wr_go && wr_addr == REG_IRQ_STAT && wr_strb[0]) begin
      irq_stat <= (irq_stat & ~wr_data[NEV-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_addr == REG_CTRL || wr_addr == REG_STATUS ||
        wr_addr == REG_IRQ_STAT || wr_addr == REG_IRQ_MASK) ?
        RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_block <= 1'b0;
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_go && wr_strb[0]) begin
      if (wr_addr == REG_CTRL) begin
        sw_block <= wr_data[CTRL_SW_BLOCK];
      end
      if (wr_addr == REG_IRQ_MASK) begin
        irq_mask <= wr_data[NEV-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  assign status_word = {16'h0000, gate_drive, boost_follower_en,
    mode_auto, mode_done, 1'b0, state, latched, dis_hold, second_overvoltage_trip_hold,
    dual_hold, first_overvoltage_trip_hold, olp_hold, bop_hold, pcl_latch};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {31'h00000000, sw_block};
        REG_STATUS: s_axi_rdata <= status_word;
        REG_IRQ_STAT: s_axi_rdata <= {24'h000000, irq_stat};
        REG_IRQ_MASK: s_axi_rdata <= {24'h000000, irq_mask};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== sim/pfcs_chk.sv ====
`timescale 1ns/100ps
module pfcs_chk
  import pfcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire pfcs_flags_t flags_in,
  input wire logic minimum_off_pulse,
  input wire logic gate_drive,
  input wire logic boost_follower_en,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  // ------------------------------------------------
  // Run length of each fault condition except the second over-voltage
  // ------------------------------------------------
  // Margin covers the input synchronisers and the state register
  localparam int MARGIN = 10;
  logic [12:0] run [7];
  logic [6:0] cond;
  assign cond = {flags_in.uvlo, flags_in.thr_low & flags_in.vref_ok,
    flags_in.first_overvoltage_trip_high, flags_in.olp_raised_low, flags_in.olp_low,
    flags_in.bop_low, flags_in.pcl_trip};
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 7; i++) begin
      if (!aresetn || !cond[i]) run[i] <= 13'h0000;
      else if (run[i] != 13'h1FFF) run[i] <= run[i] + 13'h0001;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pcl; run[0] >= PCL_CYC + MARGIN |-> !gate_drive; endproperty
  property p_bop; run[1] >= BOP_CYC + MARGIN |-> !gate_drive; endproperty
  property p_olp; run[2] >= OLP_CYC + MARGIN |-> !gate_drive; endproperty
  property p_bf;
    run[3] >= OLP_CYC + MARGIN |-> !boost_follower_en;
  endproperty
  property p_first_overvoltage_trip; run[4] >= OVP_CYC + MARGIN |-> !gate_drive; endproperty
  property p_dis; run[5] >= DIS_CYC + MARGIN |-> !gate_drive; endproperty
  property p_uvlo; flags_in.uvlo [*8] ##1 flags_in.uvlo |-> !gate_drive;
  endproperty
  property p_off; minimum_off_pulse |=> !gate_drive; endproperty
  property p_onset; $rose(gate_drive) |-> !$past(minimum_off_pulse);
  endproperty
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty

  a_pcl: assert property (p_pcl)
    else $error("drive on under current limit");
  a_bop: assert property (p_bop)
    else $error("drive on under brownout");
  a_olp: assert property (p_olp)
    else $error("drive on under open loop");
  a_bf: assert property (p_bf)
    else $error("boost follower left on");
  a_first_overvoltage_trip: assert property (p_first_overvoltage_trip)
    else $error("drive on under over-voltage");
  a_dis: assert property (p_dis)
    else $error("drive on while disabled");
  a_uvlo: assert property (p_uvlo)
    else $error("drive on in lockout");
  a_off: assert property (p_off)
    else $error("off pulse did not clear drive");
  a_onset: assert property (p_onset)
    else $error("drive set against off pulse");
  a_rd: assert property (p_rd)
    else $error("read answer late");

  c_pcl: cover property (run[0] == PCL_CYC + MARGIN);
  c_ovp: cover property (run[4] == OVP_CYC + MARGIN);
  c_bf: cover property ($fell(boost_follower_en));
endmodule

bind pfcs_fault_supervisor pfcs_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .flags_in(flags_in), .minimum_off_pulse(minimum_off_pulse),
  .gate_drive(gate_drive), .boost_follower_en(boost_follower_en),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid));

// ==== sim/pfcs_comparators.sv ====
`timescale 1ns/100ps
module pfcs_comparators
  import pfcs_pkg::*;
#(
  parameter int UVLO_MV = 11000
) (
  input int current_sense_input_mv,
  input int bop_mv,
  input int bulk_sense_input_mv,
  input int ovp_mv,
  input int thr_mv,
  input int vcc_mv,
  input logic vref_ok,
  output pfcs_flags_t flags
);
  // ------------------------------------------------
  // Comparators, levels in millivolts
  // ------------------------------------------------
  // Ideal and instant: slow edges are made by the bench holding levels
  always_comb begin
    flags.pcl_trip = current_sense_input_mv < -200;
    flags.bop_low = bop_mv < 1000;
    flags.bop_high = bop_mv > 1250;
    flags.olp_low = bulk_sense_input_mv < 500;
    flags.olp_raised_low = bulk_sense_input_mv < 800;
    // Eight percent above the 2.5 V regulation point
    flags.first_overvoltage_trip_high = bulk_sense_input_mv > 2700;
    flags.below_ref = bulk_sense_input_mv < 2500;
    flags.second_overvoltage_trip_high = ovp_mv > 2500;
    flags.second_overvoltage_trip_release = ovp_mv < 2300;
    flags.thr_low = thr_mv < 500;
    flags.supply_det = vcc_mv > 7000;
    flags.vref_ok = vref_ok;
    flags.uvlo = vcc_mv < UVLO_MV;
  end
endmodule

// ==== sim/pfc_fault_supervisor_test.sv ====
`timescale 1ns/100ps
module pfc_fault_supervisor_test
  import pfcs_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, min_off = 1'b0, pwm_on = 1'b0;
  logic bf_req = 1'b0, vref_ok = 1'b1, gate, bf_en, irq;
  int current_sense_input_mv = 0, bop_mv = 1500, bulk_sense_input_mv = 2400, ovp_mv = 2000;
  int thr_mv = 2000, vcc_mv = 12000, n_errors = 0, cmp_count = 0, cyc = 0;
  pfcs_flags_t flags;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;

  pfcs_comparators ana_u (.current_sense_input_mv(current_sense_input_mv), .bop_mv(bop_mv),
    .bulk_sense_input_mv(bulk_sense_input_mv), .ovp_mv(ovp_mv), .thr_mv(thr_mv),
    .vcc_mv(vcc_mv), .vref_ok(vref_ok), .flags(flags));

  pfcs_fault_supervisor dut_u (.aclk(aclk), .aresetn(aresetn),
    .flags_in(flags), .minimum_off_pulse(min_off), .pwm_on_set(pwm_on),
    .boost_follower_request(bf_req), .gate_drive(gate),
    .boost_follower_en(bf_en), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic results();
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // The whole sequence needs about 30000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      $display("[FAIL] %0t run timed out", $time);
      results();
    end
  end

  // ------------------------------------------------
  // Access tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata & m, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic st(input pfcs_state_t s);
    rd(REG_STATUS, 32'h00000700, {21'h0, s, 8'h00}, RESP_OKAY);
  endtask

  task automatic gt(input logic e);
    chk({31'h0, gate}, {31'h0, e});
  endtask

  // One switching cycle start, then look at the drive
  task automatic pg(input logic e);
    @(posedge aclk);
    pwm_on <= 1'b1;
    @(posedge aclk);
    pwm_on <= 1'b0;
    tick(2);
    gt(e);
  endtask

  task automatic goff(input logic p);
    @(posedge aclk);
    min_off <= 1'b1;
    pwm_on <= p;
    @(posedge aclk);
    min_off <= 1'b0;
    pwm_on <= 1'b0;
  endtask

  task automatic sv(input int v, input int o, input int n);
    @(posedge aclk);
    bulk_sense_input_mv <= v;
    ovp_mv <= o;
    tick(n);
  endtask

  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    tick(16);
    aresetn <= 1'b1;
    rd(REG_IRQ_MASK, 32'hFFFFFFFF, {24'h0, IRQ_MASK_RST}, RESP_OKAY);
    rd(8'h10, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    tick(MODE_CYC + 40);
    rd(REG_STATUS, 32'h3000, 32'h1000, RESP_OKAY);
    st(ST_RUN);
    pg(1'b1);
    goff(1'b1);
    tick(1);
    gt(1'b0);
    pg(1'b1);
    current_sense_input_mv <= -300;
    tick(30);
    current_sense_input_mv <= 0;
    tick(60);
    gt(1'b1);
    rd(REG_IRQ_STAT, 32'h1, 32'h0, RESP_OKAY);
    current_sense_input_mv <= -300;
    tick(PCL_CYC + 12);
    gt(1'b0);
    pg(1'b0);
    chk({31'h0, irq}, 32'h0);
    current_sense_input_mv <= 0;
    wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
    tick(3);
    chk({31'h0, irq}, 32'h1);
    wr(REG_IRQ_STAT, 32'h1, RESP_OKAY);
    tick(3);
    chk({31'h0, irq}, 32'h0);
    goff(1'b0);
    pg(1'b1);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_CTRL, 32'h1, 32'h1, RESP_OKAY);
    st(ST_BLOCK);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    sv(2800, 2000, OVP_CYC + 20);
    st(ST_BLOCK);
    pg(1'b0);
    sv(2600, 2000, 20);
    st(ST_BLOCK);
    sv(2400, 2000, 20);
    st(ST_RUN);
    sv(2800, 2600, OVP_CYC + 20);
    st(ST_LATCH);
    sv(2400, 2000, SOFT_CYC + 40);
    st(ST_LATCH);
    vcc_mv <= 10000;
    tick(20);
    st(ST_DOWN);
    pg(1'b0);
    vcc_mv <= 12000;
    thr_mv <= 100;
    vref_ok <= 1'b0;
    tick(MODE_CYC + 40);
    rd(REG_STATUS, 32'h3000, 32'h3000, RESP_OKAY);
    st(ST_RUN);
    thr_mv <= 2000;
    vref_ok <= 1'b1;
    sv(2800, 2600, OVP_CYC + 20);
    st(ST_HALT);
    pg(1'b0);
    sv(2400, 2400, 20);
    st(ST_HALT);
    sv(2400, 2200, 20);
    st(ST_SOFT);
    tick(SOFT_CYC);
    bop_mv <= 900;
    tick(BOP_CYC + 20);
    st(ST_HALT);
    bop_mv <= 1100;
    tick(20);
    st(ST_HALT);
    bop_mv <= 1300;
    tick(20);
    st(ST_SOFT);
    tick(SOFT_CYC);
    bf_req <= 1'b1;
    tick(4);
    chk({31'h0, bf_en}, 32'h1);
    sv(700, 2000, OLP_CYC + 20);
    chk({31'h0, bf_en}, 32'h0);
    sv(2400, 2000, 2);
    bf_req <= 1'b0;
    sv(400, 2000, OLP_CYC + 20);
    st(ST_DOWN);
    sv(2400, 2000, 20);
    st(ST_SOFT);
    tick(SOFT_CYC);
    thr_mv <= 100;
    tick(DIS_CYC + 20);
    st(ST_DOWN);
    thr_mv <= 2000;
    tick(20);
    st(ST_SOFT);
    results();
  end
endmodule
